// ### logic/gqw_qual_bank.sv
`timescale 1ns/100ps
module gqw_qual_bank
    import gqw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Samples in, qualified levels out
    gqw_filt_if.bank f
);

    logic [HIST_W-1:0] hist [NUM_PINS];

    // ------------------------------------------------------------
    // Per-pin sample history and agreement check
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic [1:0]        m;
        logic [HIST_W-1:0] nh;
        assign m  = f.mode[i*SEL_W +: SEL_W];
        assign nh = {hist[i][HIST_W-2:0], f.sample[i]};

        // The group strobe decides when a sample enters the window.
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                hist[i]   <= '0;
                f.qual[i] <= 1'b0;
            end else if (m == GQW_MODE_THREE || m == GQW_MODE_SIX) begin
                if (f.strobe[i / GROUP_PINS]) begin
                    hist[i] <= nh;
                    // Two periods between first and last of three samples.
                    if (m == GQW_MODE_THREE && (&nh[2:0] || ~|nh[2:0])) begin
                        f.qual[i] <= nh[0];
                    end
                    // Five periods between first and last of six samples.
                    if (m == GQW_MODE_SIX && (&nh || ~|nh)) begin
                        f.qual[i] <= nh[0];
                    end
                end
            end else begin
                // Unfiltered modes still pass the synchronized level only.
                hist[i]   <= {HIST_W{f.sample[i]}};
                f.qual[i] <= f.sample[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Pin 1 is the pin that runs in three-sample mode, so watch it there.
    a_three_agree: assert property (($changed(f.qual[1]) && $past(f.mode[3:2]) == 2'h1)
        |-> hist[1][2:0] == {3{f.qual[1]}}) else $error("three-sample change without agreement");
    a_six_agree: assert property (($changed(f.qual[0]) && $past(f.mode[1:0]) == 2'h2)
        |-> hist[0] == {6{f.qual[0]}}) else $error("six-sample change without agreement");
    a_sync_follow: assert property ((f.mode[1:0] == 2'h0)
        |=> f.qual[0] == $past(f.sample[0])) else $error("sync mode output lags");
    c_six_change: cover property ($changed(f.qual[0]) && f.mode[1:0] == 2'h2);

endmodule : gqw_qual_bank

// ### logic/gqw_top.sv
`timescale 1ns/100ps
module gqw_top
    import gqw_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    // Asynchronous pins
    input  wire logic [NUM_PINS-1:0]         pin_in,
    input  wire logic                        external_reset_pin_n,
    // Qualifier configuration
    input  wire logic [NUM_GROUPS*PERIOD_W-1:0] sample_period_field,
    input  wire logic [NUM_PINS*SEL_W-1:0]   pin_filter_select_regs,
    // Idle control
    input  wire logic                        idle_enter,
    input  wire logic                        flash_sleep,
    input  wire logic                        enabled_irq,
    input  wire logic                        watchdog_irq_n,
    input  wire logic [NUM_PINS-1:0]         wake_pin_mask,
    // Results
    output logic      [NUM_PINS-1:0]         pin_qual,
    output logic                             in_idle,
    output logic                             wake_seen,
    output logic                             resume_exec
);

    gqw_filt_if f ();

    // ------------------------------------------------------------
    // Input synchronizers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic                rst1;
    logic                rst2_n;

    // Two stages before any logic looks at the pins.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1  <= '0;
            sync2  <= '0;
            rst1   <= 1'b1;
            rst2_n <= 1'b1;
        end else begin
            sync1  <= pin_in;
            sync2  <= sync1;
            rst1   <= external_reset_pin_n;
            rst2_n <= rst1;
        end
    end

    // ------------------------------------------------------------
    // Configuration delay
    // ------------------------------------------------------------
    logic [NUM_GROUPS*PERIOD_W-1:0] per_d1;
    logic [NUM_GROUPS*PERIOD_W-1:0] per_eff;
    logic [NUM_GROUPS*PERIOD_W-1:0] per_prev;
    logic [NUM_PINS*SEL_W-1:0]      sel_d1;
    logic [NUM_PINS*SEL_W-1:0]      sel_eff;

    // Matching the documented pipeline so software sees the same lag.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            per_d1   <= {NUM_GROUPS{PERIOD_RST}};
            per_eff  <= {NUM_GROUPS{PERIOD_RST}};
            per_prev <= {NUM_GROUPS{PERIOD_RST}};
            sel_d1   <= {NUM_PINS{SEL_RST}};
            sel_eff  <= {NUM_PINS{SEL_RST}};
        end else begin
            per_d1   <= sample_period_field;
            per_eff  <= per_d1;
            per_prev <= per_eff;
            sel_d1   <= pin_filter_select_regs;
            sel_eff  <= sel_d1;
        end
    end

    // ------------------------------------------------------------
    // Per-group sample strobe
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt [NUM_GROUPS];

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        logic [PERIOD_W-1:0] per;
        logic                hit;
        assign per = per_eff[g*PERIOD_W +: PERIOD_W];
        // Period zero strobes every cycle, else once per 2n cycles.
        assign hit = (per == 8'h00) || (cnt[g] == ({per, 1'b0} - 9'h001));
        assign f.strobe[g] = hit;

        // A rewritten period restarts the count so no stale phase leaks in.
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                cnt[g] <= '0;
            end else if (per != per_prev[g*PERIOD_W +: PERIOD_W]) begin
                cnt[g] <= '0;
            end else if (hit) begin
                cnt[g] <= '0;
            end else begin
                cnt[g] <= cnt[g] + 9'h001;
            end
        end
    end

    assign f.sample = sync2;
    assign f.mode   = sel_eff;

    gqw_qual_bank u_bank (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .f       (f)
    );

    assign pin_qual = f.qual;

    // ------------------------------------------------------------
    // Idle wake sequencing
    // ------------------------------------------------------------
    gqw_state_t       state;
    logic [LAT_W-1:0] lat;
    logic             wake_cond;

    // Wake pins are active low on their qualified level, so a pulse that
    // is too short for the window never reaches this point.
    assign wake_cond = enabled_irq || !watchdog_irq_n || !rst2_n
                       || |(wake_pin_mask & ~f.qual);

    // Latency chosen by where code resumes from.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state       <= GQW_ST_RUN;
            lat         <= '0;
            resume_exec <= 1'b0;
        end else begin
            resume_exec <= 1'b0;
            case (state)
                GQW_ST_RUN: begin
                    if (idle_enter) begin
                        state <= GQW_ST_IDLE;
                    end
                end
                GQW_ST_IDLE: begin
                    if (wake_cond) begin
                        state <= GQW_ST_WAKE;
                        lat   <= (flash_sleep ? LAT_SLOW_CYC : LAT_FAST_CYC) - 11'h001;
                    end
                end
                GQW_ST_WAKE: begin
                    if (lat == '0) begin
                        state       <= GQW_ST_RUN;
                        resume_exec <= 1'b1;
                    end else begin
                        lat <= lat - 11'h001;
                    end
                end
                default: begin
                    state <= GQW_ST_RUN;
                end
            endcase
        end
    end

    // Status flops kept separate so outputs come straight from registers.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_idle   <= 1'b0;
            wake_seen <= 1'b0;
        end else begin
            in_idle   <= (state == GQW_ST_IDLE && !wake_cond)
                         || (state == GQW_ST_RUN && idle_enter);
            wake_seen <= (state == GQW_ST_IDLE) && wake_cond;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_strobe_zero: assert property ((per_eff[7:0] == 8'h00) |-> f.strobe[0])
        else $error("period zero missed a strobe");
    a_strobe_spacing: assert property (((f.strobe[0] && per_eff[7:0] == 8'h01)
        ##1 per_eff[7:0] == 8'h01) |-> !f.strobe[0] ##1 (per_eff[7:0] != 8'h01 || f.strobe[0]))
        else $error("period one strobe spacing wrong");
    a_cfg_delay: assert property (##2 sel_eff == $past(pin_filter_select_regs, 2))
        else $error("select not applied two cycles later");
    a_period_restart: assert property ($changed(per_eff[7:0]) |=> cnt[0] == 9'h000)
        else $error("strobe counter not restarted");
    a_resume_fast: assert property ((state == GQW_ST_IDLE && wake_cond && !flash_sleep)
        |-> ##[1:21] resume_exec) else $error("fast resume too late");
    a_idle_exit: assert property ((state == GQW_ST_IDLE && enabled_irq)
        |=> state == GQW_ST_WAKE ##1 !in_idle) else $error("irq did not end idle");

    c_wake_pin: cover property (state == GQW_ST_IDLE && |(wake_pin_mask & ~f.qual));
    c_slow_resume: cover property (resume_exec && flash_sleep);

endmodule : gqw_top

// ### pkg/gqw_filt_if.sv
`timescale 1ns/100ps
// Carries synchronized samples, strobes and modes to the filter bank.
interface gqw_filt_if;
    import gqw_pkg::*;
    logic [NUM_PINS-1:0]       sample;
    logic [NUM_GROUPS-1:0]     strobe;
    logic [NUM_PINS*SEL_W-1:0] mode;
    logic [NUM_PINS-1:0]       qual;

    modport ctrl (output sample, output strobe, output mode, input qual);
    modport bank (input sample, input strobe, input mode, output qual);
endinterface : gqw_filt_if

// ### pkg/gqw_pkg.sv
// What this block does
// - Period zero samples every system clock
// - Period n samples once per 2n clocks
// - Period field is eight bits wide
// - One period setting per eight-pin group
// - Per-pin select picks three or six samples
// - Output changes only when all samples agree
// - Pins synchronized before any qualification
// - Three-sample window spans two sample periods
// - Six-sample window spans five sample periods
// - Select writes take effect two clocks later
// - Idle exits on irq, watchdog, reset, or masked wake pin
// - Resume within 20 or 1050 cycles
package gqw_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_PINS   = 16;
    localparam int GROUP_PINS = 8;
    localparam int NUM_GROUPS = NUM_PINS / GROUP_PINS;
    localparam int PERIOD_W   = 8;
    localparam int SEL_W      = 2;
    localparam int HIST_W     = 6;
    localparam int CNT_W      = PERIOD_W + 1;

    // ------------------------------------------------------------
    // Filter select encodings and reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GQW_MODE_SYNC   = 2'h0,
        GQW_MODE_THREE  = 2'h1,
        GQW_MODE_SIX    = 2'h2,
        GQW_MODE_NOSYNC = 2'h3
    } gqw_mode_t;

    localparam logic [PERIOD_W-1:0] PERIOD_RST = 8'h00;
    localparam logic [SEL_W-1:0]    SEL_RST    = 2'h0;

    // ------------------------------------------------------------
    // Wake latency counts in system clock cycles
    // ------------------------------------------------------------
    localparam int          LAT_W        = 11;
    localparam logic [10:0] LAT_FAST_CYC = 11'h014;
    localparam logic [10:0] LAT_SLOW_CYC = 11'h41a;

    typedef enum logic [1:0] {
        GQW_ST_RUN  = 2'h0,
        GQW_ST_IDLE = 2'h1,
        GQW_ST_WAKE = 2'h3
    } gqw_state_t;

endpackage : gqw_pkg

// ### verif/gqw_pin_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side pin and wake source model
// ----------------------------------------
module gqw_pin_src
    import gqw_pkg::*;
(
    // Clock
    input  wire logic                clk_sys,
    // Driven lines
    output logic      [NUM_PINS-1:0] pin,
    output logic                     irq,
    output logic                     wdog_n,
    output logic                     xrst_n
);
    // Every source starts at its inactive level.
    initial begin
        pin    = '1;
        irq    = 1'b0;
        wdog_n = 1'b1;
        xrst_n = 1'b1;
    end

    // Moves one pin just after an edge so the device never sees a race.
    task automatic set(input int idx, input logic lvl);
        @(posedge clk_sys);
        pin[idx] <= lvl;
    endtask : set

    // Short widths are used on purpose to show that glitches are dropped.
    task automatic pulse(input int idx, input logic lvl, input int width);
        set(idx, lvl);
        repeat (width) @(posedge clk_sys);
        pin[idx] <= ~lvl;
    endtask : pulse

    // Source 3 is pin 2 pulled low; the line stays active until released.
    task automatic wake(input int src, input logic on);
        if (on) begin
            repeat (4) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        case (src)
            0: irq <= on;
            1: wdog_n <= ~on;
            2: xrst_n <= ~on;
            default: pin[2] <= ~on;
        endcase
    endtask : wake
endmodule : gqw_pin_src

// ### verif/test_gpio_input_qualifier_wake.sv
`timescale 1ns/100ps
module test_gpio_input_qualifier_wake
    import gqw_pkg::*;
;
    logic                           clk_sys;
    logic                           arst_n      = 1'b0;
    logic [NUM_GROUPS*PERIOD_W-1:0] period      = '0;
    logic [NUM_PINS*SEL_W-1:0]      sel         = '0;
    logic                           idle_enter  = 1'b0;
    logic                           flash_sleep = 1'b0;
    logic [NUM_PINS-1:0]            mask        = '0;
    logic [NUM_PINS-1:0]            pin_qual;
    logic                           in_idle;
    logic                           wake_seen;
    logic                           resume_exec;
    logic [NUM_PINS-1:0]            pin;
    logic                           irq;
    logic                           wdog_n;
    logic                           xrst_n;
    int                             mismatches  = 0;
    int                             n_checks    = 0;
    int                             n;

    gqw_pin_src src (.clk_sys(clk_sys), .pin(pin), .irq(irq), .wdog_n(wdog_n),
                     .xrst_n(xrst_n));

    gqw_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .pin_in(pin),
                 .external_reset_pin_n(xrst_n), .sample_period_field(period),
                 .pin_filter_select_regs(sel), .idle_enter(idle_enter),
                 .flash_sleep(flash_sleep), .enabled_irq(irq), .watchdog_irq_n(wdog_n),
                 .wake_pin_mask(mask), .pin_qual(pin_qual), .in_idle(in_idle),
                 .wake_seen(wake_seen), .resume_exec(resume_exec));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // A 5 ns clock, inverted every half period.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Case inequality so that an unknown output never passes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Lands 1 ns past an edge, where the outputs have settled.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // The tests need about 4500 cycles; this leaves wide margin.
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        cyc(8);
        // Sync mode: two sync stages, then one more edge.
        src.set(0, 1'b0);
        cyc(2);
        chk(pin_qual[0], 1'b1);
        cyc(1);
        chk(pin_qual[0], 1'b0);
        src.set(0, 1'b1);
        $display("test sync done");
        // Three samples at period zero: two-cycle glitch dropped, five accepted.
        @(posedge clk_sys);
        sel[3:2] <= 2'h1;
        cyc(4);
        src.pulse(1, 1'b0, 2);
        cyc(8);
        chk(pin_qual[1], 1'b1);
        src.pulse(1, 1'b0, 5);
        cyc(2);
        chk(pin_qual[1], 1'b0);
        cyc(8);
        chk(pin_qual[1], 1'b1);
        $display("test three done");
        // Six samples; group 0 at the top period, group 1 at zero.
        @(posedge clk_sys);
        period <= {8'h00, 8'hff};
        sel[1:0] <= 2'h2;
        sel[17:16] <= 2'h2;
        cyc(4);
        src.pulse(8, 1'b0, 4);
        cyc(8);
        chk(pin_qual[8], 1'b1);
        src.set(0, 1'b0);
        src.set(8, 1'b0);
        cyc(12);
        chk(pin_qual[8], 1'b0);
        chk(pin_qual[0], 1'b1);
        cyc(2000);
        chk(pin_qual[0], 1'b1);
        cyc(1200);
        chk(pin_qual[0], 1'b0);
        $display("test six done");
        // Select change lags two edges before the unfiltered path takes over.
        src.set(0, 1'b1);
        cyc(4);
        @(posedge clk_sys);
        sel[1:0] <= 2'h3;
        cyc(2);
        chk(pin_qual[0], 1'b0);
        cyc(3);
        chk(pin_qual[0], 1'b1);
        $display("test select done");
        // Period one, three samples: a three-cycle glitch meets at most two
        // samples, while seven cycles always give three agreeing samples.
        @(posedge clk_sys);
        period[7:0] <= 8'h01;
        cyc(4);
        src.pulse(1, 1'b0, 3);
        cyc(8);
        chk(pin_qual[1], 1'b1);
        src.pulse(1, 1'b0, 7);
        cyc(2);
        chk(pin_qual[1], 1'b0);
        cyc(8);
        chk(pin_qual[1], 1'b1);
        $display("test period one done");
        // A wake source outside idle is ignored.
        src.wake(0, 1'b1);
        cyc(6);
        chk(wake_seen, 1'b0);
        src.wake(0, 1'b0);
        mask <= 16'h0004;
        // Every wake source in turn; the last one with the slow flash.
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys);
            flash_sleep <= (s == 3);
            idle_enter <= 1'b1;
            @(posedge clk_sys);
            idle_enter <= 1'b0;
            #1;
            chk(in_idle, 1'b1);
            src.wake(s, 1'b1);
            for (n = 0; n < 20 && wake_seen !== 1'b1; n++) cyc(1);
            chk(wake_seen, 1'b1);
            chk(in_idle, 1'b0);
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (resume_exec !== 1'b1 && n < 1100);
            chk(n, (s == 3) ? 1050 : 20);
            src.wake(s, 1'b0);
            cyc(6);
        end
        $display("test idle done");
        print_verdict();
    end
endmodule : test_gpio_input_qualifier_wake
